// ---- design/pbs_pkg.sv ----
// Contract
// - register every synchronous input on rising edge
// - read data leaves through output register
// - 128K words of 36 bits, shared bus
// - load address only when strobed and selected
// - low address bits load the burst counter
// - counter keeps start address, wraps in 2 bits
// - advance low during burst steps the counter
// - both strobes low: processor strobe wins
// - processor strobe ignored while first select high
// - selects sampled only on address loads
// - first and third selects active low
// - global write low writes all four bytes
// - byte write needs byte write enable low
// - lane selects choose bytes, nine bits each
// - output enable steers bus without clock; here it is synchronised and registered, reaching the pins on the fifth edge
// - first read after deselect stays tristated
// - write data captured into data register
// - sleep input high idles, keeps contents
// - strap low linear, high interleaved; here the strap synchroniser's reset value is taken, so always interleaved
// - interleave by xor, linear by add mod four
// - processor-strobe write takes two clocks
// - controller-strobe write completes in one clock
// - writes force data drivers off
package pbs_pkg;
	localparam int PBS_ADDR_W = 17; // 128K words
	localparam int PBS_DATA_W = 36; // 4 lanes of 8 data + 1 parity
	localparam int PBS_LANES = 4;
	localparam int PBS_LANE_W = 9;
	localparam int PBS_BURST_W = 2;
	localparam int PBS_SYNC_STAGES = 3; // pin synchroniser depth

	// sampled synchronous controls, one bundle per edge
	typedef struct packed {
		logic [PBS_ADDR_W-1:0] addr;
		logic proc_strobe_n;
		logic ctrl_strobe_n;
		logic cs1_n;
		logic cs2;
		logic cs3_n;
		logic step_n;
		logic gw_n;
		logic bwe_n;
		logic [PBS_LANES-1:0] lane_n;
	} pbs_ctl_t;

	// access kinds seen at the core
	typedef enum logic [3:0] {
		PBS_IDLE = 4'h1,
		PBS_READ = 4'h2,
		PBS_WPEND = 4'h4,
		PBS_WRITE = 4'h8
	} pbs_state_t;
endpackage

// ---- design/pbs_mem.sv ----
`timescale 1ns/1ps
// word memory with per-lane write and registered read data
module pbs_mem import pbs_pkg::*; #(
	parameter int AW = PBS_ADDR_W,
	parameter int LANES = PBS_LANES,
	parameter int LW = PBS_LANE_W
) (
	input wire logic clock,
	input wire logic ce,
	input wire logic [AW-1:0] addr,
	input wire logic [LANES-1:0] wr_lane,
	input wire logic [LANES*LW-1:0] wdata,
	input wire logic rd_en,
	output logic [LANES*LW-1:0] rdata_q
);
	// storage has no reset: contents survive sleep and reset alike
	logic [LANES*LW-1:0] mem [0:(1<<AW)-1];

	// one lane per generate entry
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		always_ff @(posedge clock) begin
			if (ce && wr_lane[g]) begin
				mem[addr][g*LW +: LW] <= wdata[g*LW +: LW];
			end
		end
	end

	// read data registered
	always_ff @(posedge clock) begin
		if (ce && rd_en) begin
			rdata_q <= mem[addr];
		end
	end
endmodule

// ---- design/pbs_sram.sv ----
`timescale 1ns/1ps
// pipelined burst synchronous memory, device side
module pbs_sram import pbs_pkg::*; #(
	parameter int AW = PBS_ADDR_W,
	parameter int DW = PBS_DATA_W
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic [AW-1:0] addr,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_step_n,
	input wire logic global_write_n,
	input wire logic byte_write_enable_n,
	input wire logic [PBS_LANES-1:0] byte_lane_select_n,
	input wire logic chip_select_first_n,
	input wire logic chip_select_second,
	input wire logic chip_select_third_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic burst_linear_n,
	input wire logic [DW-1:0] data_in,
	output logic [DW-1:0] data_out,
	output logic data_oe,
	output logic sleeping
);
	// input register bundle
	pbs_ctl_t ctl_q;
	logic [DW-1:0] wdata_q; // on-chip write data register
	// burst address state
	logic [AW-1:0] base_q; // loaded external address
	logic [PBS_BURST_W-1:0] first_q; // first low address of the burst
	logic [PBS_BURST_W-1:0] step_q; // steps taken from first
	logic selected_q; // device selected by last load
	pbs_state_t state_q;
	logic [DW-1:0] rdata;
	logic [DW-1:0] dout_q;
	logic drive_q; // registered read-valid drive permit
	logic mask_q; // first read after deselect
	logic linear_q; // captured strap
	logic [PBS_SYNC_STAGES-1:0] oe_sync_q; // output enable synchroniser
	logic [PBS_SYNC_STAGES-1:0] zz_sync_q; // sleep synchroniser
	logic [PBS_SYNC_STAGES-1:0] mode_sync_q; // strap synchroniser
	logic sleep_q;
	logic oe_q;
	logic strap_taken_q;
	logic from_desel_q; // deselected since the last read began
	// write data and lanes held for the core edge
	logic [PBS_LANES-1:0] lanes_q_hold;
	logic [DW-1:0] wdata_q_hold;

	// decoded sampled controls
	logic sel_all;
	logic take_proc;
	logic take_ctrl;
	logic load;
	logic wr_any;
	logic [PBS_LANES-1:0] lanes;
	logic [PBS_BURST_W-1:0] low_addr;
	logic [AW-1:0] cur_addr;
	logic do_write;
	logic do_read;
	logic ce;

	// state freezes with clock enable low
	assign ce = clk_en;

	// all three selects active together
	assign sel_all = !ctl_q.cs1_n && ctl_q.cs2 && !ctl_q.cs3_n;
	// processor strobe dropped while first select high
	assign take_proc = !ctl_q.proc_strobe_n && !ctl_q.cs1_n;
	// processor strobe takes priority over controller strobe
	assign take_ctrl = !ctl_q.ctrl_strobe_n && ctl_q.proc_strobe_n;
	assign load = (take_proc || take_ctrl) && !sleep_q;

	// global write overrides lane selects
	always_comb begin
		if (!ctl_q.gw_n) begin
			lanes = {PBS_LANES{1'b1}};
		end else if (!ctl_q.bwe_n) begin
			lanes = ~ctl_q.lane_n;
		end else begin
			lanes = '0; // no write without byte enable
		end
	end
	assign wr_any = |lanes;

	// burst low address: interleave by xor, linear by add
	always_comb begin
		if (linear_q) begin
			low_addr = first_q + step_q;
		end else begin
			low_addr = first_q ^ step_q;
		end
	end
	assign cur_addr = {base_q[AW-1:PBS_BURST_W], low_addr};

	// stage 1: register every synchronous input
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctl_q <= '{default: 1'b1, addr: '0, cs2: 1'b0};
			wdata_q <= '0;
		end else if (ce) begin
			ctl_q.addr <= addr;
			ctl_q.proc_strobe_n <= processor_addr_strobe_n;
			ctl_q.ctrl_strobe_n <= controller_addr_strobe_n;
			ctl_q.cs1_n <= chip_select_first_n;
			ctl_q.cs2 <= chip_select_second;
			ctl_q.cs3_n <= chip_select_third_n;
			ctl_q.step_n <= burst_step_n;
			ctl_q.gw_n <= global_write_n;
			ctl_q.bwe_n <= byte_write_enable_n;
			ctl_q.lane_n <= byte_lane_select_n;
			wdata_q <= data_in;
		end
	end

	// pin synchronisers for asynchronous inputs; stage 0 feeds stage 1 only
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			oe_sync_q <= '1;
			zz_sync_q <= '0;
			mode_sync_q <= '1;
		end else if (ce) begin
			oe_sync_q <= {oe_sync_q[1:0], output_enable_n};
			zz_sync_q <= {zz_sync_q[1:0], sleep_request};
			mode_sync_q <= {mode_sync_q[1:0], burst_linear_n};
		end
	end

	// filtered levels: change counts once stages two and three agree
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			oe_q <= 1'b0;
			sleep_q <= 1'b0;
		end else if (ce) begin
			if (oe_sync_q[1] == oe_sync_q[2]) begin
				oe_q <= !oe_sync_q[2];
			end
			if (zz_sync_q[1] == zz_sync_q[2]) begin
				sleep_q <= zz_sync_q[2];
			end
		end
	end

	// strap taken once, on the first edge after release, from the synchroniser reset value; held thereafter
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			linear_q <= 1'b0;
			strap_taken_q <= 1'b0;
		end else if (ce && !strap_taken_q && mode_sync_q[1] == mode_sync_q[2]) begin
			linear_q <= !mode_sync_q[2];
			strap_taken_q <= 1'b1;
		end
	end

	// address register and burst counter
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			base_q <= '0;
			first_q <= '0;
			step_q <= '0;
			selected_q <= 1'b0;
		end else if (ce) begin
			if (load) begin
				// selects only matter here, on a load
				selected_q <= sel_all;
				if (sel_all) begin
					base_q <= ctl_q.addr;
					first_q <= ctl_q.addr[PBS_BURST_W-1:0];
					step_q <= '0;
				end
			end else if (!ctl_q.step_n && selected_q && state_q != PBS_WPEND) begin
				step_q <= step_q + 1'b1;
			end
			// otherwise the address holds
		end
	end

	// access sequencing
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q <= PBS_IDLE;
		end else if (ce) begin
			if (sleep_q) begin
				state_q <= PBS_IDLE; // pending access dropped in sleep
			end else if (load && !sel_all) begin
				state_q <= PBS_IDLE;
			end else if (load && take_proc) begin
				state_q <= PBS_WPEND; // controls ignored this edge
			end else if (load) begin
				state_q <= wr_any ? PBS_WRITE : PBS_READ;
			end else if (state_q == PBS_WPEND || selected_q) begin
				state_q <= wr_any ? PBS_WRITE : PBS_READ;
			end else begin
				state_q <= PBS_IDLE;
			end
		end
	end

	// write on the core edge after the decision
	assign do_write = (state_q == PBS_WRITE) && !sleep_q;
	assign do_read = (state_q == PBS_READ) && !sleep_q;

	pbs_mem #(
		.AW(AW),
		.LANES(PBS_LANES),
		.LW(PBS_LANE_W)
	) u_mem (
		.clock(clock),
		.ce(ce),
		.addr(cur_addr),
		.wr_lane(do_write ? lanes_q_hold : '0),
		.wdata(wdata_q_hold),
		.rd_en(do_read),
		.rdata_q(rdata)
	);

	// hold registers follow the sampled controls every edge
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lanes_q_hold <= '0;
			wdata_q_hold <= '0;
		end else if (ce) begin
			lanes_q_hold <= lanes;
			wdata_q_hold <= wdata_q;
		end
	end

	// output pipeline: read data one edge after the core read
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			drive_q <= 1'b0;
			mask_q <= 1'b1;
			from_desel_q <= 1'b1;
		end else if (ce) begin
			drive_q <= do_read;
			// only the first read since a deselect or reset is masked, even with writes between
			mask_q <= do_read && from_desel_q;
			if (!selected_q) begin
				from_desel_q <= 1'b1; // deselected: next read starts masked
			end else if (do_read) begin
				from_desel_q <= 1'b0;
			end
		end
	end

	// registered pins
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			data_out <= '0;
			data_oe <= 1'b0;
			sleeping <= 1'b0;
		end else if (ce) begin
			// take core data only when it holds a real read, never unread memory
			if (drive_q) begin
				data_out <= rdata;
			end
			// writes and masked reads keep drivers off whatever the enable
			data_oe <= oe_q && drive_q && !mask_q && !do_write;
			sleeping <= sleep_q;
		end
	end
endmodule

// ---- test/pbs_bus_model.sv ----
`timescale 1ns/1ps
// controller side of the shared data wire
module pbs_bus_model import pbs_pkg::*; (
	input wire logic clock,
	input wire logic [PBS_DATA_W-1:0] dev_data,
	input wire logic dev_oe,
	input wire logic [PBS_DATA_W-1:0] host_data,
	input wire logic host_oe,
	output logic [PBS_DATA_W-1:0] wire_data
);
	logic [PBS_DATA_W-1:0] last_q = '0; // level seen last cycle
	// released wire toggles, so a stale copy never passes as data
	always_comb begin
		if (host_oe) begin
			wire_data = host_data;
		end else if (dev_oe) begin
			wire_data = dev_data;
		end else begin
			wire_data = ~last_q;
		end
	end
	// remember the wire for the release pattern
	always_ff @(posedge clock) begin
		last_q <= wire_data;
	end
endmodule

// ---- test/pbs_chk.sv ----
`timescale 1ns/1ps
// pin-level watch on the memory device
module pbs_chk import pbs_pkg::*; (
	input wire logic clock,
	input wire logic rstn,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_step_n,
	input wire logic global_write_n,
	input wire logic byte_write_enable_n,
	input wire logic chip_select_first_n,
	input wire logic chip_select_second,
	input wire logic chip_select_third_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic [PBS_DATA_W-1:0] data_out,
	input wire logic data_oe,
	input wire logic sleeping
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire sel = !chip_select_first_n && chip_select_second && !chip_select_third_n; // all selects on
	wire rd_ok = global_write_n && byte_write_enable_n; // no write control
	wire quiet = processor_addr_strobe_n && controller_addr_strobe_n && burst_step_n;
	// processor read load, then a beat of advance
	sequence s_load;
		!output_enable_n && !processor_addr_strobe_n && sel && rd_ok;
	endsequence
	sequence s_step;
		!output_enable_n && !burst_step_n && processor_addr_strobe_n &&
			controller_addr_strobe_n && rd_ok;
	endsequence
	sequence s_burst;
		!output_enable_n [*3] ##1 s_load ##1 s_step ##1 s_step;
	endsequence
	AST_RST_QUIET: assert property ($rose(rstn) |-> !data_oe && !sleeping)
		else $error("outputs active at reset release");
	AST_WR_OFF: assert property (processor_addr_strobe_n && !controller_addr_strobe_n && sel &&
		!global_write_n |-> ##3 !data_oe) else $error("driving during write");
	AST_OE_OFF: assert property (output_enable_n [*6] |-> !data_oe)
		else $error("driving with output enable high");
	AST_SLEEP_ON: assert property (sleep_request [*6] |-> sleeping)
		else $error("sleep not entered");
	AST_SLEEP_OFF: assert property (!sleep_request [*6] |-> !sleeping)
		else $error("sleep not left");
	AST_DESEL_OFF: assert property (!controller_addr_strobe_n && chip_select_first_n
		|-> ##3 !data_oe) else $error("driving after deselect");
	AST_READ_ON: assert property (s_burst |-> ##3 data_oe)
		else $error("burst beat not driven");
	AST_HOLD: assert property ((quiet && rd_ok && !sleep_request) [*5] |-> $stable(data_out))
		else $error("read data moved while idle");
endmodule
bind pbs_sram pbs_chk u_chk (.clock, .rstn, .processor_addr_strobe_n, .controller_addr_strobe_n,
	.burst_step_n, .global_write_n, .byte_write_enable_n, .chip_select_first_n,
	.chip_select_second, .chip_select_third_n, .output_enable_n, .sleep_request, .data_out,
	.data_oe, .sleeping);

// ---- test/pipelined_burst_sync_sram_test.sv ----
`timescale 1ns/1ps
module pipelined_burst_sync_sram_test;
	import pbs_pkg::*;
	localparam pbs_ctl_t IDLE = '{addr: 17'h0, proc_strobe_n: 1'h1, ctrl_strobe_n: 1'h1,
		cs1_n: 1'h0, cs2: 1'h1, cs3_n: 1'h0, step_n: 1'h1, gw_n: 1'h1, bwe_n: 1'h1, lane_n: 4'hF};
	logic clock = 1'h0;
	logic rstn = 1'h0;
	logic oe_n = 1'h0; // left low through writes: the device must override it
	logic zz = 1'h0;
	logic hen = 1'h0; // bench drives the data wire
	logic [35:0] hd = '0;
	logic [35:0] dout, din;
	logic doe, slp;
	pbs_ctl_t c = IDLE; // synchronous pin bundle
	logic [35:0] mem [4]; // reference words 0..3
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	pbs_sram u_dut (.clock, .rstn, .clk_en(1'h1), .addr(c.addr),
		.processor_addr_strobe_n(c.proc_strobe_n), .controller_addr_strobe_n(c.ctrl_strobe_n),
		.burst_step_n(c.step_n), .global_write_n(c.gw_n), .byte_write_enable_n(c.bwe_n),
		.byte_lane_select_n(c.lane_n), .chip_select_first_n(c.cs1_n), .chip_select_second(c.cs2),
		.chip_select_third_n(c.cs3_n), .output_enable_n(oe_n), .sleep_request(zz),
		.burst_linear_n(1'h1), .data_in(din), .data_out(dout), .data_oe(doe), .sleeping(slp));
	pbs_bus_model u_bus (.clock, .dev_data(dout), .dev_oe(doe), .host_data(hd), .host_oe(hen),
		.wire_data(din));
	initial forever #2.5 clock = ~clock;
	// cut a hang short
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(string n, logic [35:0] e, logic [35:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// one word write; processor form loads first, controls one edge later
	task automatic wr(logic proc, logic [16:0] a, logic [35:0] d, logic gw, logic [3:0] ln);
		pbs_ctl_t v;
		v = IDLE;
		v.addr = a;
		if (proc) begin
			v.proc_strobe_n = 1'h0;
			@(posedge clock);
			c <= v;
			v = IDLE;
		end else v.ctrl_strobe_n = 1'h0;
		v.gw_n = gw;
		v.bwe_n = 1'h0;
		v.lane_n = ln;
		@(posedge clock);
		c <= v;
		hen <= 1'h1;
		hd <= d;
		@(posedge clock);
		c <= IDLE;
		hen <= 1'h0;
		for (int g = 0; g < 4; g++) if (!gw || !ln[g]) mem[a[1:0]][9*g +: 9] = d[9*g +: 9];
	endtask
	// burst read of n beats; hi lifts output enable, fresh deselects first
	task automatic burst(pbs_ctl_t v, int n, logic hi, logic fresh);
		pbs_ctl_t w;
		w = IDLE;
		w.ctrl_strobe_n = !fresh;
		w.cs1_n = fresh;
		@(posedge clock);
		c <= w;
		oe_n <= hi;
		@(posedge clock);
		c <= v;
		// processor load parks one edge, so the first word shows on the fifth edge
		for (int k = 1; k <= n + 4; k++) begin
			w = IDLE;
			w.step_n = 1'(k > n); // first advance is ignored while the load parks
			w.cs1_n = 1'h1; // selects ignored between loads
			@(posedge clock);
			c <= w;
			#1;
			if (k >= 5) chk("word", mem[v.addr[1:0] ^ 2'(k - 5)], dout);
			if (k >= 5) chk("drive", 36'((k > 5 || !fresh) && !hi), 36'(doe));
		end
		@(posedge clock);
		c <= IDLE;
		oe_n <= 1'h0;
	endtask
	initial begin
		pbs_ctl_t v;
		repeat (5) @(posedge clock);
		rstn <= 1'h1;
		repeat (4) @(posedge clock);
		for (int i = 0; i < 4; i++) wr(1'h0, 17'(i), {9{4'(i + 5)}}, 1'h0, 4'hF);
		wr(1'h0, 17'h2, 36'hFEDCBA987, 1'h1, 4'hA);
		wr(1'h1, 17'h0, 36'h123456789, 1'h0, 4'hF);
		zz <= 1'h1;
		repeat (8) @(posedge clock);
		chk("sleeping", 36'h1, 36'(slp));
		zz <= 1'h0;
		repeat (8) @(posedge clock);
		chk("awake", 36'h0, 36'(slp));
		v = IDLE;
		v.addr = 17'h1;
		v.proc_strobe_n = 1'h0;
		burst(v, 4, 1'h0, 1'h0);
		burst(v, 2, 1'h1, 1'h0);
		v.addr = 17'h3;
		v.ctrl_strobe_n = 1'h0;
		v.gw_n = 1'h0;
		burst(v, 1, 1'h0, 1'h1);
		summarize();
	end
endmodule
